//--- hdl/mdc_regs.svh
// register addresses, field positions and cycle counts of the multiply divide coprocessor
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH
`define MDC_ADDR_OPND0 8'he9
`define MDC_ADDR_OPND1 8'hea
`define MDC_ADDR_OPND2 8'heb
`define MDC_ADDR_OPND3 8'hec
`define MDC_ADDR_OPND4 8'hed
`define MDC_ADDR_OPND5 8'hc7
`define MDC_ADDR_CTRL 8'hef
`define MDC_IDX_NONE 3'h7
`define MDC_IDX_B0 3'h0
`define MDC_IDX_B1 3'h1
`define MDC_IDX_B2 3'h2
`define MDC_IDX_B3 3'h3
`define MDC_IDX_B4 3'h4
`define MDC_IDX_B5 3'h5
`define MDC_BIT_ERR 7
`define MDC_BIT_OV 6
`define MDC_BIT_DIR 5
`define MDC_CNT_MSB 4
`define MDC_CTRL_RESET 8'h00
`define MDC_CNT_MAX 5'h1f
`define MDC_LAT_DIV32 5'h11
`define MDC_LAT_DIV16 5'h09
`define MDC_LAT_MUL 5'h0b
`define MDC_LAT_SHIFT_BASE 6'h02
`define MDC_LAT_NORM_BASE 6'h03
`define MDC_MUL_LIMIT 32'h0000ffff
`endif

//--- hdl/mdc_pkg.sv
// types shared by the multiply divide coprocessor modules
package mdc_pkg;
  typedef enum logic [2:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM} mdc_op_e;
  typedef enum logic {SEQ_IDLE, SEQ_ARMED} mdc_seq_e;
endpackage

//--- hdl/mdc_if.sv
// link between register front end and arithmetic engine
`timescale 1ns/100ps
`default_nettype none
interface mdc_if;
  logic start;
  logic abort;
  mdc_pkg::mdc_op_e op;
  logic [47:0] opnd;
  logic dir;
  logic [4:0] cnt_in;
  logic busy;
  logic done;
  logic [47:0] res;
  logic [4:0] cnt_out;
  logic ov;
  modport ctl (output start, abort, op, opnd, dir, cnt_in,
               input busy, done, res, cnt_out, ov);
  modport eng (input start, abort, op, opnd, dir, cnt_in,
               output busy, done, res, cnt_out, ov);
endinterface
`default_nettype wire

//--- hdl/mdc_engine.sv
// arithmetic engine: computes at launch, then counts out the execution time
`timescale 1ns/100ps
`default_nettype none
`include "mdc_regs.svh"
module mdc_engine (
  input wire logic i_clk,
  input wire logic i_rst,
  mdc_if.eng bus
);
  logic [4:0] cnt;
  logic [47:0] next_res;
  logic [4:0] next_cnt;
  logic [4:0] next_lat;
  logic next_ov;
  logic [31:0] num;
  logic [15:0] div;
  logic [31:0] prod;
  logic [4:0] zeros;

  // leading zero count, capped at the largest shift count
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] z;
    z = `MDC_CNT_MAX;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        z = 5'(31 - i);
      end
    end
    return z;
  endfunction

  // cycles for a count: half the count rounded up plus a base
  function automatic logic [4:0] half_lat(input logic [4:0] c, input logic [5:0] base);
    logic [5:0] s;
    s = ((6'(c) + 6'h01) >> 1) + base;
    return s[4:0];
  endfunction

  // unsigned result, flag and duration of the requested operation
  always_comb begin
    num = bus.opnd[31:0];
    div = bus.opnd[47:32];
    prod = 32'(bus.opnd[15:0] * div);
    zeros = lead_zeros(num);
    next_res = bus.opnd;
    next_cnt = bus.cnt_in;
    next_ov = 1'b0;
    next_lat = `MDC_LAT_MUL;
    case (bus.op)
      mdc_pkg::OP_DIV32: begin
        next_lat = `MDC_LAT_DIV32;
        next_ov = (div == 16'h0000);
        if (div == 16'h0000) begin
          next_res = {num[15:0], 32'hffffffff};
        end else begin
          next_res = {16'(num % div), num / 32'(div)};
        end
      end
      mdc_pkg::OP_DIV16: begin
        next_lat = `MDC_LAT_DIV16;
        next_ov = (div == 16'h0000);
        if (div == 16'h0000) begin
          next_res = {num[15:0], num[31:16], 16'hffff};
        end else begin
          next_res = {num[15:0] % div, num[31:16], num[15:0] / div};
        end
      end
      mdc_pkg::OP_MUL: begin
        next_lat = `MDC_LAT_MUL;
        next_ov = (prod > `MDC_MUL_LIMIT);
        next_res = {div, prod};
      end
      mdc_pkg::OP_SHIFT: begin
        next_lat = half_lat(bus.cnt_in, `MDC_LAT_SHIFT_BASE);
        if (bus.dir) begin
          next_res = {div, num >> bus.cnt_in};
        end else begin
          next_res = {div, num << bus.cnt_in};
        end
      end
      mdc_pkg::OP_NORM: begin
        next_lat = half_lat(zeros, `MDC_LAT_NORM_BASE);
        next_ov = num[31];
        next_cnt = zeros;
        next_res = {div, num << zeros};
      end
      default: begin
        next_lat = `MDC_LAT_MUL;
      end
    endcase
  end

  // runs on its own once launched; abort drops the running calculation
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.busy <= 1'b0;
      cnt <= 5'h00;
      bus.res <= 48'h000000000000;
      bus.cnt_out <= 5'h00;
      bus.ov <= 1'b0;
    end else if (bus.abort) begin
      bus.busy <= 1'b0;
    end else if (bus.start) begin
      bus.busy <= 1'b1;
      cnt <= next_lat - 5'h01;
      bus.res <= next_res;
      bus.cnt_out <= next_cnt;
      bus.ov <= next_ov;
    end else if (bus.busy) begin
      if (cnt == 5'h00) begin
        bus.busy <= 1'b0;
      end else begin
        cnt <= cnt - 5'h01;
      end
    end
  end

  assign bus.done = bus.busy && (cnt == 5'h00);

  done_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
    bus.done |=> !bus.busy) else $error("engine busy past its final count");
endmodule
`default_nettype wire

//--- hdl/mdc_top.sv
// multiply divide coprocessor: register front end, load sequence and flags
`timescale 1ns/100ps
`default_nettype none
`include "mdc_regs.svh"
// Behaviour
// - byte2 or byte3 written selects 32/16 division
// - byte4 selects 16/16 division, byte1 multiplication
// - byte5 or control write launches calculation
// - unit computes alone, parallel to core
// - shift lasts 3 to 18 cycles
// - normalize lasts 3 to 19 cycles
// - last result read ends the calculation
// - normalize shifts left until top bit set
// - zero shift count selects normalize
// - shift distance equals shift count value
// - direction bit: zero left, one right
// - zeros fill vacated bit positions
// - error detection armed by byte0, ended by read
// - write during execution sets error flag
// - operand read during execution sets error flag
// - error flag cleared only by control read
// - overflow on zero divisor, big product, normalized input
// - overflow cleared by every other operation
// - software cannot write overflow flag
// - all arithmetic unsigned
// - results overwrite operands
module mdc_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_busy
);
  mdc_if u_if ();
  localparam logic [7:0] ctrl_reset = `MDC_CTRL_RESET; // control image after reset

  logic [47:0] opnd;
  logic [47:0] next_opnd;
  logic dir;
  logic [4:0] shift_count;
  logic err;
  logic ov;
  logic seq_en;
  logic saw_hi;
  logic saw_b4;
  logic saw_b1;
  mdc_pkg::mdc_seq_e seq;
  mdc_pkg::mdc_op_e cur_op;
  mdc_pkg::mdc_op_e next_op;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic wr_opnd;
  logic wr_ctrl;
  logic rd_opnd;
  logic rd_ctrl;
  logic busy;
  logic load;
  logic start;
  logic err_set;
  logic last_read;
  logic [4:0] run_len;

  // operand byte index for an address, none when unmapped
  function automatic logic [2:0] opnd_index(input logic [7:0] a);
    logic [2:0] idx;
    if (a == `MDC_ADDR_OPND0) begin
      idx = `MDC_IDX_B0;
    end else if (a == `MDC_ADDR_OPND1) begin
      idx = `MDC_IDX_B1;
    end else if (a == `MDC_ADDR_OPND2) begin
      idx = `MDC_IDX_B2;
    end else if (a == `MDC_ADDR_OPND3) begin
      idx = `MDC_IDX_B3;
    end else if (a == `MDC_ADDR_OPND4) begin
      idx = `MDC_IDX_B4;
    end else if (a == `MDC_ADDR_OPND5) begin
      idx = `MDC_IDX_B5;
    end else begin
      idx = `MDC_IDX_NONE;
    end
    return idx;
  endfunction

  // access decode
  assign wr_idx = opnd_index(i_addr);
  assign rd_idx = wr_idx;
  assign wr_opnd = i_wr && (wr_idx != `MDC_IDX_NONE);
  assign rd_opnd = i_rd && (rd_idx != `MDC_IDX_NONE);
  assign wr_ctrl = i_wr && (i_addr == `MDC_ADDR_CTRL);
  assign rd_ctrl = i_rd && (i_addr == `MDC_ADDR_CTRL);
  assign busy = u_if.busy;
  assign o_busy = u_if.busy;

  // any register write while executing disrupts the calculation
  assign u_if.abort = (wr_opnd || wr_ctrl) && busy;
  assign load = u_if.done && !u_if.abort;
  assign err_set = u_if.abort || (rd_opnd && busy && seq_en);

  // operand image including the byte written this cycle
  always_comb begin
    next_opnd = opnd;
    if (wr_opnd) begin
      next_opnd[{wr_idx, 3'h0} +: 8] = i_wdata;
    end
  end

  // closing write picks the operation from what was written since byte0
  always_comb begin
    next_op = mdc_pkg::OP_NONE;
    if (seq == mdc_pkg::SEQ_ARMED && !busy) begin
      if (wr_opnd && wr_idx == `MDC_IDX_B5) begin
        if (saw_hi) begin
          next_op = mdc_pkg::OP_DIV32;
        end else if (saw_b4) begin
          next_op = mdc_pkg::OP_DIV16;
        end else if (saw_b1) begin
          next_op = mdc_pkg::OP_MUL;
        end
      end else if (wr_ctrl) begin
        if (i_wdata[`MDC_CNT_MSB:0] == 5'h00) begin
          next_op = mdc_pkg::OP_NORM;
        end else begin
          next_op = mdc_pkg::OP_SHIFT;
        end
      end
    end
  end

  assign start = (next_op != mdc_pkg::OP_NONE);
  assign u_if.start = start;
  assign u_if.op = next_op;
  assign u_if.opnd = next_opnd;
  assign u_if.dir = wr_ctrl ? i_wdata[`MDC_BIT_DIR] : dir;
  assign u_if.cnt_in = wr_ctrl ? i_wdata[`MDC_CNT_MSB:0] : shift_count;

  mdc_engine u_eng (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .bus(u_if.eng)
  );

  // load sequence tracking; the later of byte1 and byte4 picks the operation
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq <= mdc_pkg::SEQ_IDLE;
      saw_hi <= 1'b0;
      saw_b4 <= 1'b0;
      saw_b1 <= 1'b0;
    end else if (wr_opnd && wr_idx == `MDC_IDX_B0) begin
      seq <= mdc_pkg::SEQ_ARMED;
      saw_hi <= 1'b0;
      saw_b4 <= 1'b0;
      saw_b1 <= 1'b0;
    end else if (start) begin
      seq <= mdc_pkg::SEQ_IDLE;
    end else if (wr_opnd && seq == mdc_pkg::SEQ_ARMED) begin
      case (wr_idx)
        `MDC_IDX_B2, `MDC_IDX_B3: saw_hi <= 1'b1;
        `MDC_IDX_B4: begin
          saw_b4 <= 1'b1;
          saw_b1 <= 1'b0;
        end
        `MDC_IDX_B1: begin
          saw_b1 <= 1'b1;
          saw_b4 <= 1'b0;
        end
        default: saw_hi <= saw_hi;
      endcase
    end
  end

  // operation of the calculation in flight or last launched
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_op <= mdc_pkg::OP_NONE;
    end else if (start) begin
      cur_op <= next_op;
    end
  end

  // operand bytes: written by software, replaced by results
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      opnd <= 48'h000000000000;
    end else if (load) begin
      opnd <= u_if.res;
    end else begin
      opnd <= next_opnd;
    end
  end

  // direction and shift count; normalize returns its shift total
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir <= ctrl_reset[`MDC_BIT_DIR];
      shift_count <= ctrl_reset[`MDC_CNT_MSB:0];
    end else if (wr_ctrl) begin
      dir <= i_wdata[`MDC_BIT_DIR];
      shift_count <= i_wdata[`MDC_CNT_MSB:0];
    end else if (load && cur_op == mdc_pkg::OP_NORM) begin
      shift_count <= u_if.cnt_out;
    end
  end

  // overflow follows only the arithmetic outcome
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ov <= ctrl_reset[`MDC_BIT_OV];
    end else if (load) begin
      ov <= u_if.ov;
    end
  end

  // error flag: set wins over the clearing control read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err <= ctrl_reset[`MDC_BIT_ERR];
    end else if (err_set) begin
      err <= 1'b1;
    end else if (rd_ctrl) begin
      err <= 1'b0;
    end
  end

  // final result read depends on the operation type
  always_comb begin
    last_read = 1'b0;
    if (rd_opnd && !busy) begin
      if (cur_op == mdc_pkg::OP_DIV32 || cur_op == mdc_pkg::OP_DIV16) begin
        last_read = (rd_idx == `MDC_IDX_B5);
      end else begin
        last_read = (rd_idx == `MDC_IDX_B3);
      end
    end
  end

  // error detection window
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      seq_en <= 1'b0;
    end else if (wr_opnd && wr_idx == `MDC_IDX_B0) begin
      seq_en <= 1'b1;
    end else if (last_read) begin
      seq_en <= 1'b0;
    end
  end

  // registered read data; unmapped addresses read zero
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (rd_opnd) begin
      o_rdata <= opnd[{rd_idx, 3'h0} +: 8];
    end else if (rd_ctrl) begin
      o_rdata <= {err, ov, dir, shift_count};
    end else if (i_rd) begin
      o_rdata <= 8'h00;
    end
  end

  // busy cycle count, read only by checks
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      run_len <= 5'h00;
    end else if (start) begin
      run_len <= 5'h00;
    end else if (busy) begin
      run_len <= run_len + 5'h01;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_launch_div32;
    start && next_op == mdc_pkg::OP_DIV32;
  endsequence
  sequence s_launch_div16;
    start && next_op == mdc_pkg::OP_DIV16;
  endsequence
  sequence s_launch_mul;
    start && next_op == mdc_pkg::OP_MUL;
  endsequence
  sequence s_quiet;
    !i_wr;
  endsequence

  div32_time_a: assert property (disable iff (i_rst || u_if.abort)
    s_launch_div32 |-> ##17 u_if.done) else $error("32/16 division not done in 17 cycles");
  div16_time_a: assert property (disable iff (i_rst || u_if.abort)
    s_launch_div16 |-> ##9 u_if.done) else $error("16/16 division not done in 9 cycles");
  mul_time_a: assert property (disable iff (i_rst || u_if.abort)
    s_launch_mul |-> ##11 u_if.done) else $error("multiplication not done in 11 cycles");
  shift_time_a: assert property (
    load && cur_op == mdc_pkg::OP_SHIFT |->
      run_len == 5'(((shift_count + 6'h01) >> 1) + 6'h01)) else $error("shift duration wrong");
  norm_time_a: assert property (
    load && cur_op == mdc_pkg::OP_NORM |->
      run_len == 5'(((u_if.cnt_out + 6'h01) >> 1) + 6'h02)) else $error("normalize duration wrong");
  norm_result_a: assert property (
    load && cur_op == mdc_pkg::OP_NORM && !u_if.ov |=> opnd[31] || opnd[31:0] == 32'h0)
    else $error("normalize left top bit clear");
  mul_ovf_a: assert property (
    load && cur_op == mdc_pkg::OP_MUL |=> ov == (opnd[31:16] != 16'h0000))
    else $error("multiply overflow flag mismatch");
  shift_ovf_a: assert property (
    load && cur_op == mdc_pkg::OP_SHIFT |=> !ov) else $error("shift left overflow set");
  err_write_a: assert property (
    busy && (wr_opnd || wr_ctrl) |=> err && !busy) else $error("write during run not flagged");
  err_read_a: assert property (
    busy && seq_en && rd_opnd && !i_wr |=> err && (busy != $past(u_if.done)))
    else $error("read during run mishandled");
  err_clear_a: assert property (
    (rd_ctrl && !busy) and s_quiet |=> !err) else $error("control read did not clear error");
  seq_end_a: assert property (
    last_read and s_quiet |=> !seq_en) else $error("final read left detection on");

  // flag ownership, launch, detection window, shift results and division overflow
  err_hold_a: assert property (
    !busy && !rd_ctrl |=> err == $past(err))
    else $error("error flag changed without control read");
  ov_write_a: assert property (
    wr_ctrl && !load |=> ov == $past(ov))
    else $error("control write changed overflow flag");
  launch_run_a: assert property (
    start |=> busy) else $error("launch did not start execution");
  arm_detect_a: assert property (
    wr_opnd && wr_idx == `MDC_IDX_B0 |=> seq_en)
    else $error("byte0 write did not arm detection");
  shr_result_a: assert property (
    load && cur_op == mdc_pkg::OP_SHIFT && dir |=>
      opnd[31:0] == ($past(opnd[31:0]) >> shift_count)) else $error("right shift result wrong");
  shl_result_a: assert property (
    load && cur_op == mdc_pkg::OP_SHIFT && !dir |=>
      opnd[31:0] == ($past(opnd[31:0]) << shift_count)) else $error("left shift result wrong");
  div_ovf_a: assert property (
    load && (cur_op == mdc_pkg::OP_DIV32 || cur_op == mdc_pkg::OP_DIV16) |=>
      ov == ($past(opnd[47:32]) == 16'h0000)) else $error("division overflow flag mismatch");
endmodule
`default_nettype wire

//--- testbench/mdc_core_model.sv
// core model: issues register writes and reads to the coprocessor
`timescale 1ns/100ps
`default_nettype none
module mdc_core_model (
  input wire logic i_clk,
  output logic [7:0] o_addr,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata
);
  int gap = 0; // idle cycles before each access, models a slow core

  // bus idle at time zero
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end

  // one write, held over exactly one sampling edge, then lines scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a; // released lines never keep the last value
    o_wdata <= ~d;
  endtask

  // one read, data taken half a cycle after the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

//--- testbench/mdc_top_test.sv
// self-checking bench for the multiply divide coprocessor
`timescale 1ns/100ps
`default_nettype none
`include "mdc_regs.svh"
module mdc_top_test;
  logic i_clk;
  logic i_rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  logic busy;
  logic [7:0] b;
  logic [31:0] v;
  logic [15:0] pend[$];
  int fails = 0;
  int check_count = 0;
  // shift and normalize cases: control write, operand, result, control read, cycles
  logic [7:0] cw[7] = '{8'hc1, 8'he1, 8'hdf, 8'hff, 8'hc0, 8'hc0, 8'hc0};
  logic [31:0] si[7] = '{32'h80000001, 32'h80000001, 32'hffffffff, 32'hffffffff,
                         32'h00001000, 32'h40000000, 32'h80000000};
  logic [31:0] so[7] = '{32'h00000002, 32'h40000000, 32'h80000000, 32'h00000001,
                         32'h80000000, 32'h80000000, 32'h80000000};
  logic [7:0] ce[7] = '{8'h01, 8'h21, 8'h1f, 8'h3f, 8'h13, 8'h01, 8'h40};
  int nx[7] = '{3, 3, 18, 18, 13, 4, 3};

  // 10 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  mdc_top i_dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_addr(addr),
    .i_wr(wr),
    .i_rd(rd),
    .i_wdata(wdata),
    .o_rdata(rdata),
    .o_busy(busy)
  );

  mdc_core_model i_core (
    .i_clk(i_clk),
    .o_addr(addr),
    .o_wr(wr),
    .o_rd(rd),
    .o_wdata(wdata),
    .i_rdata(rdata)
  );

  task automatic finish_test();
    if (fails == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    pend.push_back({a, d});
  endtask

  // send queued writes in order
  task automatic flush();
    while (pend.size() > 0) begin
      i_core.wr(pend[0][15:8], pend[0][7:0]);
      void'(pend.pop_front());
    end
  endtask

  // count busy cycles, bounded
  task automatic wait_idle(output int n);
    n = 0;
    @(negedge i_clk);
    while (busy === 1'b1 && n < 100) begin
      n++;
      @(negedge i_clk);
    end
  endtask

  task automatic go(input int n_exp);
    int n;
    flush();
    wait_idle(n);
    chk(32'(n), 32'(n_exp));
  endtask

  // bytes 0..3, byte 3 read last
  task automatic rd32(output logic [31:0] r);
    for (int i = 0; i < 4; i++) begin
      i_core.rd(`MDC_ADDR_OPND0 + i[7:0], b);
      r[8*i +: 8] = b;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_core.rd(a, b);
    chk({24'h0, b}, {24'h0, exp});
  endtask

  // hang guard, far beyond the expected run of under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    int n;
    i_rst = 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values and an unmapped address
    rd32(v);
    chk(v, 32'h0);
    rd_chk(`MDC_ADDR_OPND4, 8'h00);
    rd_chk(`MDC_ADDR_OPND5, 8'h00);
    rd_chk(`MDC_ADDR_CTRL, `MDC_CTRL_RESET);
    rd_chk(8'h00, 8'h00);
    // multiplication 0x1234 x 0x0002
    put(`MDC_ADDR_OPND0, 8'h34);
    put(`MDC_ADDR_OPND4, 8'h02);
    put(`MDC_ADDR_OPND1, 8'h12);
    put(`MDC_ADDR_OPND5, 8'h00);
    go(11);
    rd32(v);
    chk(v, 32'h00002468);
    rd_chk(`MDC_ADDR_CTRL, 8'h00);
    // multiplication above 16 bits
    put(`MDC_ADDR_OPND0, 8'h34);
    put(`MDC_ADDR_OPND4, 8'h00);
    put(`MDC_ADDR_OPND1, 8'h12);
    put(`MDC_ADDR_OPND5, 8'h01);
    go(11);
    rd32(v);
    chk(v, 32'h00123400);
    rd_chk(`MDC_ADDR_CTRL, 8'h40);
    // 32 by 16 division 0x12345678 / 0x1234
    put(`MDC_ADDR_OPND0, 8'h78);
    put(`MDC_ADDR_OPND1, 8'h56);
    put(`MDC_ADDR_OPND2, 8'h34);
    put(`MDC_ADDR_OPND3, 8'h12);
    put(`MDC_ADDR_OPND4, 8'h34);
    put(`MDC_ADDR_OPND5, 8'h12);
    go(17);
    rd32(v);
    chk(v, 32'h00010004);
    rd_chk(`MDC_ADDR_OPND4, 8'ha8);
    rd_chk(`MDC_ADDR_OPND5, 8'h0d);
    rd_chk(`MDC_ADDR_CTRL, 8'h00);
    // 16 by 16 division from a slow core, bytes 2..3 untouched
    i_core.gap = 3;
    put(`MDC_ADDR_OPND0, 8'h34);
    put(`MDC_ADDR_OPND1, 8'h12);
    put(`MDC_ADDR_OPND4, 8'h10);
    put(`MDC_ADDR_OPND5, 8'h00);
    go(9);
    i_core.gap = 0;
    rd32(v);
    chk(v, 32'h00010123);
    rd_chk(`MDC_ADDR_OPND4, 8'h04);
    rd_chk(`MDC_ADDR_OPND5, 8'h00);
    // division by zero
    put(`MDC_ADDR_OPND0, 8'h34);
    put(`MDC_ADDR_OPND1, 8'h12);
    put(`MDC_ADDR_OPND4, 8'h00);
    put(`MDC_ADDR_OPND5, 8'h00);
    go(9);
    rd32(v);
    chk(v, 32'h0001ffff);
    rd_chk(`MDC_ADDR_OPND4, 8'h34);
    rd_chk(`MDC_ADDR_OPND5, 8'h12);
    rd_chk(`MDC_ADDR_CTRL, 8'h40);
    // shifts both ways at both count limits, then normalize, flag bits written high
    for (int k = 0; k < 7; k++) begin
      for (int j = 0; j < 4; j++) begin
        put(`MDC_ADDR_OPND0 + j[7:0], si[k][8*j +: 8]);
      end
      put(`MDC_ADDR_CTRL, cw[k]);
      go(nx[k]);
      rd32(v);
      chk(v, so[k]);
      rd_chk(`MDC_ADDR_CTRL, ce[k]);
    end
    // operand read during execution: flag set, calculation completes
    put(`MDC_ADDR_OPND0, 8'h02);
    put(`MDC_ADDR_OPND4, 8'h03);
    put(`MDC_ADDR_OPND1, 8'h00);
    put(`MDC_ADDR_OPND5, 8'h00);
    flush();
    rd_chk(`MDC_ADDR_OPND0, 8'h02);
    wait_idle(n);
    rd32(v);
    chk(v, 32'h00000006);
    rd_chk(`MDC_ADDR_CTRL, 8'h80);
    rd_chk(`MDC_ADDR_CTRL, 8'h00);
    // write during execution: calculation abandoned, flag set
    put(`MDC_ADDR_OPND0, 8'h02);
    put(`MDC_ADDR_OPND4, 8'h03);
    put(`MDC_ADDR_OPND1, 8'h00);
    put(`MDC_ADDR_OPND5, 8'h00);
    flush();
    i_core.wr(`MDC_ADDR_OPND1, 8'h55);
    wait_idle(n);
    chk(32'(n), 32'h0);
    rd32(v);
    chk(v, 32'h00005502);
    rd_chk(`MDC_ADDR_CTRL, 8'h80);
    rd_chk(`MDC_ADDR_CTRL, 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
